//--- hdl/rbl_chan.sv
`timescale 1ns/1ns
// ****************************************************************
// one counter: pending-load flag, holding register, latches
// ****************************************************************
module rbl_chan
   import rbl_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic ctrl_wr_i, // control word for this counter
   input wire logic [5:0] ctrl_i, // access, mode, base fields
   input wire logic data_wr_i, // count byte written
   input wire logic [7:0] data_i, // count byte
   input wire logic data_rd_i, // data byte consumed
   input wire logic rb_cnt_i, // read-back count latch
   input wire logic rb_sts_i, // read-back status latch
   input wire logic load_i, // holding -> counting element
   input wire logic out_lvl_i, // counter output level
   input wire logic [15:0] count_i, // live counting element
   output logic [7:0] rd_data_o, // byte a read would return
   output logic null_o, // pending-load flag
   output logic [5:0] fields_o, // programmed fields
   output logic [15:0] hold_o, // count holding register
   output logic hold_wr_o, // holding register complete
   output logic cnt_lat_o, // count latched, unread
   output logic sts_lat_o // status latched, unread
);
   logic [5:0] fields_reg; // access/mode/base
   logic null_reg; // pending-load flag
   logic wr_hi_reg; // next write is high byte
   logic rd_hi_reg; // next read is high byte
   logic [15:0] hold_reg; // count_holding_register
   logic hold_wr_reg; // completion pulse
   logic [15:0] output_latch; // frozen count
   logic cnt_val_reg; // output_latch holds unread count
   logic [7:0] sts_reg; // frozen status byte
   logic sts_val_reg; // sts_reg unread
   logic [1:0] acc; // access field
   logic complete; // last byte of a count arrives
   logic [15:0] src; // count being read

   assign acc = fields_reg[5:4];
   // only the last byte of a word-mode pair completes a count
   assign complete = data_wr_i && (acc != RBL_ACC_WORD || wr_hi_reg);

   // ****************************************************************
   // programming state
   // ****************************************************************
   // fields and write byte pointer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fields_reg <= RBL_FIELDS_RST;
         wr_hi_reg <= 1'b0;
      end
      else if (ctrl_wr_i)
      begin
         fields_reg <= ctrl_i;
         wr_hi_reg <= 1'b0; // new control word restarts pairing
      end
      else if (data_wr_i && acc == RBL_ACC_WORD)
         wr_hi_reg <= !wr_hi_reg;
   end

   // holding register and completion pulse
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold_reg <= RBL_HOLD_RST;
         hold_wr_reg <= 1'b0;
      end
      else
      begin
         hold_wr_reg <= complete;
         if (data_wr_i)
         begin
            if (acc == RBL_ACC_MSB)
               hold_reg <= {data_i, 8'h00};
            else if (acc == RBL_ACC_WORD && wr_hi_reg)
               hold_reg[15:8] <= data_i;
            else if (acc == RBL_ACC_WORD)
               hold_reg[7:0] <= data_i;
            else
               hold_reg <= {8'h00, data_i};
         end
      end
   end

   // pending-load flag: a set in the load cycle wins over the clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         null_reg <= 1'b0;
      else if (ctrl_wr_i || complete)
         null_reg <= 1'b1;
      else if (load_i)
         null_reg <= 1'b0;
   end

   // ****************************************************************
   // latches and read sequence
   // ****************************************************************
   // count latch: first request wins, frozen until read out
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_val_reg <= 1'b0;
         output_latch <= 16'h0000;
      end
      else if (ctrl_wr_i)
         cnt_val_reg <= 1'b0; // reprogramming drops a stale latch
      else if (rb_cnt_i && !cnt_val_reg)
      begin
         output_latch <= count_i;
         cnt_val_reg <= 1'b1;
      end
      else if (data_rd_i && !sts_val_reg && cnt_val_reg)
      begin
         // release after the last byte of the format
         if (acc != RBL_ACC_WORD || rd_hi_reg)
            cnt_val_reg <= 1'b0;
      end
   end

   // status latch: later requests ignored until it is read
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sts_val_reg <= 1'b0;
         sts_reg <= 8'h00;
      end
      else if (ctrl_wr_i)
         sts_val_reg <= 1'b0;
      else if (rb_sts_i && !sts_val_reg)
      begin
         sts_reg <= {out_lvl_i, null_reg, fields_reg};
         sts_val_reg <= 1'b1;
      end
      else if (data_rd_i)
         sts_val_reg <= 1'b0;
   end

   // read byte pointer; a status read does not move it
   always_ff @(posedge clk_i)
   begin
      if (rst_i || ctrl_wr_i)
         rd_hi_reg <= 1'b0;
      else if (data_rd_i && !sts_val_reg && acc == RBL_ACC_WORD)
         rd_hi_reg <= !rd_hi_reg;
   end

   // status always comes out ahead of any latched count
   assign src = cnt_val_reg ? output_latch : count_i;
   always_comb
   begin
      if (sts_val_reg)
         rd_data_o = sts_reg;
      else if (acc == RBL_ACC_MSB || (acc == RBL_ACC_WORD && rd_hi_reg))
         rd_data_o = src[15:8];
      else
         rd_data_o = src[7:0];
   end

   assign null_o = null_reg;
   assign fields_o = fields_reg;
   assign hold_o = hold_reg;
   assign hold_wr_o = hold_wr_reg;
   assign cnt_lat_o = cnt_val_reg;
   assign sts_lat_o = sts_val_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_both_latched;
      sts_val_reg && cnt_val_reg && data_rd_i && !ctrl_wr_i;
   endsequence
   // a low byte read before the status latch leaves the pointer on
   // the high byte, so either byte of the frozen count may follow
   sequence s_count_next;
      !sts_val_reg && cnt_val_reg && (rd_data_o == output_latch[7:0] ||
      rd_data_o == output_latch[15:8]);
   endsequence

   property p_fields;
      ctrl_wr_i |=> fields_o == $past(ctrl_i) && null_o;
   endproperty
   a_fields: assert property (p_fields)
      else $error("fields not taken from control word");

   property p_null_cr;
      complete && !ctrl_wr_i |=> null_o ##1 hold_wr_o == 1'b0;
   endproperty
   a_null_cr: assert property (p_null_cr)
      else $error("count write did not set pending flag");

   property p_first_byte;
      data_wr_i && acc == RBL_ACC_WORD && !wr_hi_reg && !load_i &&
      !ctrl_wr_i |=> null_o == $past(null_o) && !hold_wr_o;
   endproperty
   a_first_byte: assert property (p_first_byte)
      else $error("first byte moved pending flag");

   property p_load_clear;
      load_i && !ctrl_wr_i && !complete |=> !null_o;
   endproperty
   a_load_clear: assert property (p_load_clear)
      else $error("load did not clear pending flag");

   property p_sts_keep;
      sts_val_reg && !data_rd_i && !ctrl_wr_i |=> $stable(sts_reg) &&
      sts_val_reg;
   endproperty
   a_sts_keep: assert property (p_sts_keep)
      else $error("latched status overwritten");

   property p_cnt_frozen;
      cnt_val_reg && !data_rd_i && !ctrl_wr_i |=> $stable(output_latch)
      && cnt_val_reg;
   endproperty
   a_cnt_frozen: assert property (p_cnt_frozen)
      else $error("latched count moved before read");

   property p_order;
      s_both_latched |=> s_count_next;
   endproperty
   a_order: assert property (p_order)
      else $error("count came before status");

   property p_release;
      cnt_val_reg && !sts_val_reg && data_rd_i && !ctrl_wr_i &&
      (acc != RBL_ACC_WORD || rd_hi_reg) |=> !cnt_val_reg;
   endproperty
   a_release: assert property (p_release)
      else $error("latch not released after full read");
endmodule : rbl_chan

//--- hdl/rbl_top.sv
`timescale 1ns/1ns
// ****************************************************************
// read-back status latch, wishbone slave
// ****************************************************************
//
// Contract
// - status low six bits show programmed fields
// - control word sets pending-load flag
// - count write sets pending-load flag
// - holding to counting transfer clears flag
// - each counter owns its own flag
// - word mode sets flag on second byte
// - repeated status latches keep the first
// - both latch bits low latch both
// - repeated combined latches keep the first
// - status read first, then count bytes
// - status first regardless of request order
// - multi-counter command skips already latched counters
// - status top bits: output level, pending flag
// - fully read latch released, others kept
module rbl_top
   import rbl_pkg::*;
(
   input wire logic clk_i, // 50 MHz clock
   input wire logic rst_i, // sync reset, high
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   input wire logic we_i, // wishbone write
   input wire logic [7:0] adr_i, // wishbone byte address
   input wire logic [3:0] sel_i, // wishbone byte enables
   input wire logic [31:0] dat_i, // wishbone write data
   output logic [31:0] dat_o, // wishbone read data
   output logic ack_o, // wishbone acknowledge
   input wire logic [2:0] load_i, // per counter: holding -> counting
   input wire logic [2:0] out_lvl_i, // per counter output level
   input wire logic [47:0] count_i, // live counts, counter 0 low
   output logic [47:0] hold_o, // holding registers, counter 0 low
   output logic [2:0] hold_wr_o, // holding register complete pulse
   output logic [17:0] fields_o, // programmed fields, counter 0 low
   output logic [2:0] null_o // pending-load flags
);
   // ****************************************************************
   // bus slave
   // ****************************************************************
   logic ack_reg; // one-cycle acknowledge
   logic [31:0] dat_reg; // read data, registered
   logic req; // new request, not yet answered
   logic take; // edge at which the access takes effect
   logic wr_take; // write takes effect now
   logic rd_take; // read takes effect now
   logic [7:0] cw; // control byte being written
   logic cw_rb; // control byte is a read-back command
   logic [1:0] cw_sel; // counter addressed by control byte
   logic [1:0] chan_idx; // data port addressed, 3 = none
   logic is_ctrl; // control address hit
   logic is_stat; // state register hit

   // map an address to a data port; 3 means not a data port
   function automatic logic [1:0] data_port(input logic [7:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      if (w == RBL_ADR_DATA0)
         data_port = 2'd0;
      else if (w == RBL_ADR_DATA1)
         data_port = 2'd1;
      else if (w == RBL_ADR_DATA2)
         data_port = 2'd2;
      else
         data_port = 2'd3;
   endfunction : data_port

   assign chan_idx = data_port(adr_i);
   assign is_ctrl = {adr_i[7:2], 2'b00} == RBL_ADR_CTRL;
   assign is_stat = {adr_i[7:2], 2'b00} == RBL_ADR_STAT;
   assign req = cyc_i && stb_i && !ack_reg;
   // effects land on the edge where the master sees ack; the byte
   // in lane 0 must be enabled for a write to count
   assign take = cyc_i && stb_i && ack_reg;
   assign wr_take = take && we_i && sel_i[0];
   assign rd_take = take && !we_i;
   assign cw = dat_i[7:0];
   assign cw_sel = cw[RBL_CW_SEL_HI:RBL_CW_SEL_LO];
   assign cw_rb = cw_sel == RBL_SEL_RB;

   // acknowledge every access one cycle after it is seen;
   // unmapped reads answer zero, unmapped writes are dropped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= req;
   end

   // ****************************************************************
   // counter channels
   // ****************************************************************
   logic [2:0] ctrl_wr; // control word per counter
   logic [2:0] data_wr; // count byte per counter
   logic [2:0] data_rd; // data read per counter
   logic [2:0] rb_cnt; // read-back count latch per counter
   logic [2:0] rb_sts; // read-back status latch per counter
   logic [7:0] rd_byte [RBL_NUM_CNT]; // read byte per counter
   logic [2:0] cnt_lat; // count latched flags
   logic [2:0] sts_lat; // status latched flags

   generate
      for (genvar i = 0; i < RBL_NUM_CNT; i++)
      begin : g_chan
         // plain latch commands are not served here and are ignored
         assign ctrl_wr[i] = wr_take && is_ctrl && !cw_rb &&
            cw_sel == 2'(i) && cw[5:4] != RBL_ACC_LATCH;
         assign data_wr[i] = wr_take && chan_idx == 2'(i);
         assign data_rd[i] = rd_take && chan_idx == 2'(i);
         // read-back: select bit high, latch requests active low
         assign rb_cnt[i] = wr_take && is_ctrl && cw_rb &&
            cw[RBL_RB_SEL0 + i] && !cw[RBL_RB_CNT_N];
         assign rb_sts[i] = wr_take && is_ctrl && cw_rb &&
            cw[RBL_RB_SEL0 + i] && !cw[RBL_RB_STS_N];

         rbl_chan u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ctrl_wr_i(ctrl_wr[i]),
            .ctrl_i(cw[5:0]),
            .data_wr_i(data_wr[i]),
            .data_i(cw),
            .data_rd_i(data_rd[i]),
            .rb_cnt_i(rb_cnt[i]),
            .rb_sts_i(rb_sts[i]),
            .load_i(load_i[i]),
            .out_lvl_i(out_lvl_i[i]),
            .count_i(count_i[16*i +: 16]),
            .rd_data_o(rd_byte[i]),
            .null_o(null_o[i]),
            .fields_o(fields_o[6*i +: 6]),
            .hold_o(hold_o[16*i +: 16]),
            .hold_wr_o(hold_wr_o[i]),
            .cnt_lat_o(cnt_lat[i]),
            .sts_lat_o(sts_lat[i])
         );
      end
   endgenerate

   // ****************************************************************
   // read data
   // ****************************************************************
   // sampled at the request, stable while ack stands: the channel
   // state only moves on the acknowledged edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_reg <= 32'h0000_0000;
      else if (req && !we_i)
      begin
         if (chan_idx != 2'd3)
            dat_reg <= {24'h00_0000, rd_byte[chan_idx]};
         else if (is_stat)
         begin
            dat_reg <= 32'h0000_0000;
            dat_reg[RBL_SR_NULL +: 3] <= null_o;
            dat_reg[RBL_SR_STS +: 3] <= sts_lat;
            dat_reg[RBL_SR_CNT +: 3] <= cnt_lat;
         end
         else
            dat_reg <= 32'h0000_0000; // control and unmapped read zero
      end
   end

   assign dat_o = dat_reg;
   assign ack_o = ack_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rb_both0;
      wr_take && is_ctrl && cw == 8'hC2;
   endsequence

   property p_ack_one;
      req |=> ack_o ##1 !ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("ack not a single cycle after request");

   property p_iso;
      ctrl_wr[0] && !load_i[1] && !data_wr[1] |=> $stable(null_o[1]);
   endproperty
   a_iso: assert property (p_iso)
      else $error("counter 0 write moved counter 1 flag");

   property p_both0;
      s_rb_both0 |=> cnt_lat[0] && sts_lat[0] && !cnt_lat[1] == 
      !$past(cnt_lat[1]);
   endproperty
   a_both0: assert property (p_both0)
      else $error("combined read-back did not latch both");

   property p_ctrl_null;
      wr_take && is_ctrl && cw == 8'h34 |=> null_o[0] &&
      fields_o[5:0] == 6'h34;
   endproperty
   a_ctrl_null: assert property (p_ctrl_null)
      else $error("control word did not set pending flag");

   property p_status_bits;
      wr_take && is_ctrl && cw == 8'hE2 && !sts_lat[0] |=> sts_lat[0]
      ##1 req && !we_i && chan_idx == 2'd0 |=> dat_o[RBL_ST_NULL] ==
      $past(null_o[0], 2);
   endproperty
   a_status_bits: assert property (p_status_bits)
      else $error("status byte pending bit wrong");

   property p_keep_other;
      data_rd[0] |=> $stable(cnt_lat[2:1]);
   endproperty
   a_keep_other: assert property (p_keep_other)
      else $error("read of counter 0 released another latch");
endmodule : rbl_top

//--- shared/rbl_pkg.sv
// ****************************************************************
// read-back latch constants
// ****************************************************************
package rbl_pkg;
   // number of counters served
   localparam int RBL_NUM_CNT = 3;
   // wishbone byte offsets
   localparam logic [7:0] RBL_ADR_CTRL = 8'h00; // control / read-back
   localparam logic [7:0] RBL_ADR_DATA0 = 8'h04; // counter 0 data
   localparam logic [7:0] RBL_ADR_DATA1 = 8'h08; // counter 1 data
   localparam logic [7:0] RBL_ADR_DATA2 = 8'h0C; // counter 2 data
   localparam logic [7:0] RBL_ADR_STAT = 8'h10; // block state view
   // control word fields
   localparam int RBL_CW_SEL_HI = 7; // counter select msb
   localparam int RBL_CW_SEL_LO = 6; // counter select lsb
   localparam logic [1:0] RBL_SEL_RB = 2'h3; // read-back command code
   localparam logic [1:0] RBL_ACC_LATCH = 2'h0; // plain latch, ignored
   localparam logic [1:0] RBL_ACC_LSB = 2'h1; // low byte only
   localparam logic [1:0] RBL_ACC_MSB = 2'h2; // high byte only
   localparam logic [1:0] RBL_ACC_WORD = 2'h3; // low then high byte
   // read-back command fields (active low latch requests)
   localparam int RBL_RB_CNT_N = 5; // low = latch count
   localparam int RBL_RB_STS_N = 4; // low = latch status
   localparam int RBL_RB_SEL0 = 1; // counter 0 select bit
   // status byte fields
   localparam int RBL_ST_OUT = 7; // output pin level
   localparam int RBL_ST_NULL = 6; // pending-load flag
   // block state register fields
   localparam int RBL_SR_NULL = 0; // pending-load flags [2:0]
   localparam int RBL_SR_STS = 4; // status latched [6:4]
   localparam int RBL_SR_CNT = 8; // count latched [10:8]
   // reset values
   localparam logic [5:0] RBL_FIELDS_RST = 6'h00; // programmed fields
   localparam logic [15:0] RBL_HOLD_RST = 16'h0000; // holding register
endpackage : rbl_pkg

//--- test/rbl_ce_model.sv
`timescale 1ns/1ns
// ****************************************************************
// counting element model, far side of the latch block
// ****************************************************************
module rbl_ce_model
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic stall_i, // hold back loads, slow partner
   input wire logic [47:0] hold_i, // holding registers
   input wire logic [2:0] hold_wr_i, // holding register complete
   output logic [2:0] load_o, // holding to counting pulse
   output logic [2:0] out_lvl_o, // output pin levels
   output logic [47:0] count_o // live counts
);
   logic [2:0] pend_reg; // load owed per counter
   // each counter loads only its own value; a stall delays the load
   always_ff @(posedge clk_i)
   begin
      for (int n = 0; n < 3; n++)
      begin
         load_o[n] <= 1'b0;
         if (rst_i)
         begin
            pend_reg[n] <= 1'b0;
            count_o[16*n +: 16] <= 16'h0000;
         end
         else if (pend_reg[n] && !stall_i)
         begin
            // one clean transfer pulse
            load_o[n] <= 1'b1;
            pend_reg[n] <= 1'b0;
            count_o[16*n +: 16] <= hold_i[16*n +: 16];
         end
         else
         begin
            // free running down count between loads
            pend_reg[n] <= pend_reg[n] | hold_wr_i[n];
            count_o[16*n +: 16] <= count_o[16*n +: 16] - 16'h0001;
         end
      end
   end
   // output pin follows a count bit so it keeps moving
   always_comb
   begin
      for (int m = 0; m < 3; m++)
      begin
         out_lvl_o[m] = count_o[16*m + 5];
      end
   end
endmodule : rbl_ce_model

//--- test/testbench.sv
`timescale 1ns/1ns
// ****************************************************************
// read-back latch bench
// ****************************************************************
module testbench
   import rbl_pkg::*;
;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, stall; // bench driven
   logic [7:0] adr_i; // bus address
   logic [3:0] sel_i; // byte enables
   logic [31:0] dat_i, dat_o, rd_q; // bus data, captured read
   logic ack_o; // bus acknowledge
   logic [2:0] load_w, out_w, hwr_w, null_w, snap_out; // link bits
   logic [47:0] cnt_w, hold_w, snap_cnt; // link counts
   logic [17:0] fields_w; // programmed fields
   logic [15:0] c1_cnt, c0_cnt; // counts frozen at latch time
   logic c0_out, c1_out, c2_out; // pin levels at latch time
   int err_count = 0; // mismatches
   int tests_run = 0; // comparisons
   rbl_top rbl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .load_i(load_w),
      .out_lvl_i(out_w), .count_i(cnt_w), .hold_o(hold_w),
      .hold_wr_o(hwr_w), .fields_o(fields_w), .null_o(null_w));
   rbl_ce_model rbl_ce_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .stall_i(stall), .hold_i(hold_w), .hold_wr_i(hwr_w),
      .load_o(load_w), .out_lvl_o(out_w), .count_o(cnt_w));
   // ****************************************************************
   // clock, watchdog, verdict
   // ****************************************************************
   always #10 clk_i = ~clk_i;
   // the whole run takes a few hundred cycles
   initial
   begin
      repeat (3000) @(posedge clk_i);
      err_count++;
      print_verdict();
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask : check
   // ****************************************************************
   // wishbone classic master
   // ****************************************************************
   // entered just after an edge; link values are snapped at the ack
   // edge, the same edge at which the block latches them
   task automatic wb(input logic we, input logic [7:0] adr,
      input logic [7:0] dat, input logic [3:0] sel);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      sel_i <= sel;
      dat_i <= {24'h000000, dat};
      // no answer time assumed: only the watchdog ends this wait
      @(posedge clk_i);
      while (ack_o !== 1'b1)
      begin
         @(posedge clk_i);
      end
      rd_q = dat_o;
      snap_cnt = cnt_w;
      snap_out = out_w;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      wb(1'b1, adr, dat, 4'h1);
   endtask : wr
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 8'h00, 4'h1);
      check(rd_q, exp);
   endtask : rd
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      clk_i = 1'b0; rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0;
      we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0; stall = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(32'(null_w), 32'h0);
      check(32'(fields_w), 32'h0);
      // counter 0, word access, mode 2
      wr(RBL_ADR_CTRL, 8'h34);
      check(32'(null_w), 32'h1);
      check(32'(fields_w[5:0]), 32'h34);
      wr(RBL_ADR_DATA0, 8'h21);
      wr(RBL_ADR_DATA0, 8'h43);
      repeat (4) @(posedge clk_i);
      check(32'(null_w), 32'h0);
      check(32'(hold_w[15:0]), 32'h4321);
      // slow partner: the load waits, first byte leaves flag alone
      stall <= 1'b1;
      wr(RBL_ADR_DATA0, 8'h65);
      check(32'(null_w), 32'h0);
      wr(RBL_ADR_DATA0, 8'h87);
      check(32'(null_w), 32'h1);
      check(32'(hold_w[15:0]), 32'h8765);
      stall <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(32'(null_w), 32'h0);
      // combined latch, repeated while the count keeps running
      wr(RBL_ADR_CTRL, 8'hC2);
      c0_cnt = snap_cnt[15:0];
      c0_out = snap_out[0];
      repeat (40) @(posedge clk_i);
      wr(RBL_ADR_CTRL, 8'hC2);
      rd(RBL_ADR_STAT, 32'h110);
      rd(RBL_ADR_DATA0, {24'h0, c0_out, 7'h34});
      rd(RBL_ADR_DATA0, 32'(c0_cnt[7:0]));
      rd(RBL_ADR_DATA0, 32'(c0_cnt[15:8]));
      rd(RBL_ADR_STAT, 32'h0);
      // counters 1 and 2: counter 1 count latched before status, counter 2 status only
      wr(RBL_ADR_CTRL, 8'h74);
      wr(RBL_ADR_CTRL, 8'hB4);
      check(32'(null_w), 32'h6);
      wr(RBL_ADR_DATA1, 8'h11);
      wr(RBL_ADR_DATA1, 8'h22);
      wr(RBL_ADR_DATA2, 8'h33);
      wr(RBL_ADR_DATA2, 8'h44);
      repeat (4) @(posedge clk_i);
      check(32'(null_w), 32'h0);
      wr(RBL_ADR_CTRL, 8'hD4);
      c1_cnt = snap_cnt[31:16];
      repeat (20) @(posedge clk_i);
      wr(RBL_ADR_CTRL, 8'hEC);
      c1_out = snap_out[1];
      c2_out = snap_out[2];
      // new count raises the flag; a second status latch is ignored
      stall <= 1'b1;
      wr(RBL_ADR_DATA1, 8'h55);
      wr(RBL_ADR_DATA1, 8'h66);
      repeat (30) @(posedge clk_i);
      wr(RBL_ADR_CTRL, 8'hEC);
      rd(RBL_ADR_STAT, 32'h262);
      rd(RBL_ADR_DATA1, {24'h0, c1_out, 7'h34});
      rd(RBL_ADR_DATA1, 32'(c1_cnt[7:0]));
      rd(RBL_ADR_DATA1, 32'(c1_cnt[15:8]));
      rd(RBL_ADR_DATA2, {24'h0, c2_out, 7'h34});
      rd(RBL_ADR_STAT, 32'h2);
      // status only, taken while a new count still waits for its load
      wr(RBL_ADR_DATA0, 8'h12);
      wr(RBL_ADR_DATA0, 8'h34);
      check(32'(null_w), 32'h3);
      wr(RBL_ADR_CTRL, 8'hE2);
      c0_out = snap_out[0];
      rd(RBL_ADR_DATA0, {24'h0, c0_out, 7'h74});
      stall <= 1'b0;
      // refused accesses: a valid control word with lane 0 disabled
      wb(1'b1, RBL_ADR_CTRL, 8'hB0, 4'h0);
      check(32'(fields_w[17:12]), 32'h34);
      rd(8'h14, 32'h0);
      rd(RBL_ADR_CTRL, 32'h0);
      print_verdict();
   end
endmodule : testbench
